//--- rtl/css_pkg.sv
// Shared constants, encodings and carrier types for the code segment security block.
package css_pkg;

   localparam int          CSS_AW        = 24;
   localparam int          CSS_DW        = 32;
   localparam int          CSS_WB_AW     = 8;

   // Boot security select codes.
   localparam logic [2:0]  CSS_BSS_NONE  = 3'h7;
   localparam logic [2:0]  CSS_BSS_STD_S = 3'h6;
   localparam logic [2:0]  CSS_BSS_STD_L = 3'h5;
   localparam logic [2:0]  CSS_BSS_HI_S  = 3'h2;
   localparam logic [2:0]  CSS_BSS_HI_L  = 3'h1;

   // Boot segment bounds and high-security entry window.
   localparam logic [CSS_AW-1:0] CSS_BOOT_START = 24'h00_0200;
   localparam logic [CSS_AW-1:0] CSS_BOOT_END_S = 24'h00_0AFE;
   localparam logic [CSS_AW-1:0] CSS_BOOT_END_L = 24'h00_15FE;
   localparam logic [CSS_AW-1:0] CSS_ENTRY_END  = 24'h00_023F;

   // Configuration word layouts; unprogrammed bits read as one.
   localparam int          CSS_BWORD_W   = 4;
   localparam int          CSS_GWORD_W   = 2;
   localparam int          CSS_BOOT_WRITE_LOCK_BIT  = 0;
   localparam int          CSS_BSS_LSB   = 1;
   localparam int          CSS_GENERAL_WRITE_LOCK_BIT  = 0;
   localparam int          CSS_GSS_BIT   = 1;
   localparam logic [CSS_BWORD_W-1:0] CSS_BWORD_ERASED = 4'hF;
   localparam logic [CSS_GWORD_W-1:0] CSS_GWORD_ERASED = 2'h3;

   // Register byte offsets.
   localparam logic [CSS_WB_AW-1:0] CSS_REG_BOOT_CFG = 8'h00;
   localparam logic [CSS_WB_AW-1:0] CSS_REG_GEN_CFG  = 8'h04;
   localparam logic [CSS_WB_AW-1:0] CSS_REG_CTRL     = 8'h08;
   localparam logic [CSS_WB_AW-1:0] CSS_REG_STATUS   = 8'h0C;
   localparam logic [CSS_WB_AW-1:0] CSS_REG_MASK     = 8'h10;
   localparam logic [CSS_WB_AW-1:0] CSS_REG_STATE    = 8'h14;

   localparam int          CSS_CTRL_ERASE_BIT = 0;

   // Event bits of status and mask.
   localparam int          CSS_EV_W        = 4;
   localparam int          CSS_EV_PORT_RD  = 0;
   localparam int          CSS_EV_CROSS    = 1;
   localparam int          CSS_EV_WLOCK    = 2;
   localparam int          CSS_EV_ENTRY    = 3;

   typedef enum logic [1:0] {
      CSS_ACC_READ  = 2'h0,
      CSS_ACC_WRITE = 2'h1,
      CSS_ACC_FLOW  = 2'h2,
      CSS_ACC_FETCH = 2'h3
   } css_acc_t;

   // Security level, one-hot.
   typedef enum logic [2:0] {
      CSS_LVL_NONE = 3'b001,
      CSS_LVL_STD  = 3'b010,
      CSS_LVL_HIGH = 3'b100
   } css_lvl_t;

   typedef struct packed {
      logic              valid;
      logic              from_port;
      css_acc_t          kind;
      logic [CSS_AW-1:0] pc;
      logic [CSS_AW-1:0] target;
   } css_req_t;

   typedef struct packed {
      logic grant;
      logic deny;
      logic illegal_reset;
   } css_resp_t;

endpackage

//--- rtl/css_seg_class.sv
// Address classifier: boot segment membership and high-security entry window.
`timescale 1ns/1ps
module css_seg_class
   import css_pkg::*;
(
   input  wire logic [CSS_AW-1:0] addr,
   input  wire logic              boot_en,
   input  wire logic [CSS_AW-1:0] boot_end,
   output logic                   in_boot,
   output logic                   in_entry
);

   always_comb begin
      in_boot  = boot_en && (addr >= CSS_BOOT_START) && (addr <= boot_end);
      in_entry = in_boot && (addr <= CSS_ENTRY_END);
   end

endmodule

//--- rtl/css_top.sv
// Code segment security: access checking, config shadow and Wishbone register file.
//
// Contract
// - Select 111 disables boot segment entirely.
// - Select 110/101: standard security, deny port reads.
// - General code cannot read/write boot flash.
// - Boot code may always read boot flash; writes follow boot write lock.
// - Select 010/001: standard plus entry restrictions.
// - General-to-boot jumps only into 0x200-0x23F.
// - Jump beyond entry window forces illegal-opcode reset.
// - General select 1 leaves general segment readable.
// - General select 0 denies port reads there.
// - Boot write lock 0 forbids boot writes.
// - General write lock 0 forbids general writes.
// - Config bits only clear; bulk erase restores.
// - Boot segment 0200h to 0AFEh or 15FEh.
`timescale 1ns/1ps
module css_top
   import css_pkg::*;
(
   input  wire logic                   core_clk,
   input  wire logic                   rst_n,
   input  wire logic                   wb_cyc_i,
   input  wire logic                   wb_stb_i,
   input  wire logic                   wb_we_i,
   input  wire logic [CSS_WB_AW-1:0]   wb_adr_i,
   input  wire logic [3:0]             wb_sel_i,
   input  wire logic [CSS_DW-1:0]      wb_dat_i,
   output logic [CSS_DW-1:0]           wb_dat_o,
   output logic                        wb_ack_o,
   output logic                        irq,
   input  wire logic [CSS_BWORD_W-1:0] boot_segment_config_word,
   input  wire logic [CSS_GWORD_W-1:0] general_segment_config_word,
   output logic [CSS_BWORD_W-1:0]      boot_cfg_image,
   output logic [CSS_GWORD_W-1:0]      gen_cfg_image,
   input  wire css_req_t               acc_req,
   output css_resp_t                   acc_resp
);

   logic [CSS_BWORD_W-1:0] boot_cfg_r;
   logic [CSS_GWORD_W-1:0] gen_cfg_r;
   logic                   loaded_r;
   logic [CSS_EV_W-1:0]    status_r;
   logic [CSS_EV_W-1:0]    status_nxt;
   logic [CSS_EV_W-1:0]    mask_r;
   logic [CSS_EV_W-1:0]    mask_nxt;
   logic [CSS_EV_W-1:0]    ev_set;
   logic                   ack_r;
   logic [CSS_DW-1:0]      rdat_r;
   logic [CSS_DW-1:0]      rdat_nxt;
   logic                   irq_r;
   css_resp_t              resp_r;
   css_resp_t              resp_nxt;

   logic [2:0]             boot_security_select;
   logic                   boot_write_lock;
   logic                   gss;
   logic                   general_write_lock;
   css_lvl_t               lvl;
   logic                   boot_en;
   logic [CSS_AW-1:0]      boot_end;
   logic [1:0]             seg_in_boot;
   logic [1:0]             seg_in_entry;
   logic [CSS_AW-1:0]      seg_addr [2];
   logic                   wb_req;
   logic                   wb_wr;
   logic                   lane0;

   assign boot_security_select  = boot_cfg_r[CSS_BSS_LSB +: 3];
   assign boot_write_lock = boot_cfg_r[CSS_BOOT_WRITE_LOCK_BIT];
   assign gss  = gen_cfg_r[CSS_GSS_BIT];
   assign general_write_lock = gen_cfg_r[CSS_GENERAL_WRITE_LOCK_BIT];

   // Reserved select codes fall back to no boot segment.
   always_comb begin
      case (boot_security_select)
         CSS_BSS_STD_S, CSS_BSS_STD_L: lvl = CSS_LVL_STD;
         CSS_BSS_HI_S, CSS_BSS_HI_L:   lvl = CSS_LVL_HIGH;
         default:                      lvl = CSS_LVL_NONE;
      endcase
   end

   assign boot_en  = (lvl != CSS_LVL_NONE);
   assign boot_end = ((boot_security_select == CSS_BSS_STD_S) || (boot_security_select == CSS_BSS_HI_S)) ?
                     CSS_BOOT_END_S : CSS_BOOT_END_L;

   assign seg_addr[0] = acc_req.pc;
   assign seg_addr[1] = acc_req.target;

   // Index 0 classifies the executing pc, index 1 the access target.
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_class
         css_seg_class u_class (
            .addr     (seg_addr[gi]),
            .boot_en  (boot_en),
            .boot_end (boot_end),
            .in_boot  (seg_in_boot[gi]),
            .in_entry (seg_in_entry[gi])
         );
      end
   endgenerate

   // Access decision, registered one cycle after the request.
   always_comb begin
      resp_nxt = '0;
      ev_set   = '0;
      if (acc_req.valid) begin
         resp_nxt.grant = 1'b1;
         if (acc_req.from_port) begin
            if (acc_req.kind == CSS_ACC_WRITE) begin
               if ((seg_in_boot[1] && !boot_write_lock) || (!seg_in_boot[1] && !general_write_lock)) begin
                  resp_nxt.grant = 1'b0;
                  ev_set[CSS_EV_WLOCK] = 1'b1;
               end
            end else if (seg_in_boot[1]) begin
               resp_nxt.grant = 1'b0;
               ev_set[CSS_EV_PORT_RD] = 1'b1;
            end else if (!gss) begin
               resp_nxt.grant = 1'b0;
               ev_set[CSS_EV_PORT_RD] = 1'b1;
            end
         end else begin
            case (acc_req.kind)
               CSS_ACC_READ: begin
                  if (seg_in_boot[1] && !seg_in_boot[0]) begin
                     resp_nxt.grant = 1'b0;
                     ev_set[CSS_EV_CROSS] = 1'b1;
                  end
               end
               CSS_ACC_WRITE: begin
                  if (seg_in_boot[1] && !seg_in_boot[0]) begin
                     resp_nxt.grant = 1'b0;
                     ev_set[CSS_EV_CROSS] = 1'b1;
                  end else if ((seg_in_boot[1] && !boot_write_lock) ||
                               (!seg_in_boot[1] && !general_write_lock)) begin
                     resp_nxt.grant = 1'b0;
                     ev_set[CSS_EV_WLOCK] = 1'b1;
                  end
               end
               CSS_ACC_FLOW: begin
                  if ((lvl == CSS_LVL_HIGH) && !seg_in_boot[0] && seg_in_boot[1]
                      && !seg_in_entry[1]) begin
                     resp_nxt.grant         = 1'b0;
                     resp_nxt.illegal_reset = 1'b1;
                     ev_set[CSS_EV_ENTRY]   = 1'b1;
                  end
               end
               default: begin
                  resp_nxt.grant = 1'b1;
               end
            endcase
         end
         resp_nxt.deny = !resp_nxt.grant;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         resp_r <= '0;
      end else begin
         resp_r <= resp_nxt;
      end
   end

   // Bus handshake: answer one cycle after the request, drop the cycle after.
   // Writes land at the edge where the master samples ack high, never earlier.
   assign wb_req = wb_cyc_i && wb_stb_i && !ack_r;
   assign wb_wr  = wb_cyc_i && wb_stb_i && wb_we_i && ack_r;
   assign lane0  = wb_sel_i[0];

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= wb_req;
      end
   end

   // Config shadow: held erased in reset, loaded from the array after release,
   // then only cleared by programming or set again by a bulk erase.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         boot_cfg_r <= CSS_BWORD_ERASED;
         gen_cfg_r  <= CSS_GWORD_ERASED;
         loaded_r   <= 1'b0;
      end else if (!loaded_r) begin
         boot_cfg_r <= boot_segment_config_word;
         gen_cfg_r  <= general_segment_config_word;
         loaded_r   <= 1'b1;
      end else if (wb_wr && lane0 && (wb_adr_i == CSS_REG_CTRL)
                   && wb_dat_i[CSS_CTRL_ERASE_BIT]) begin
         boot_cfg_r <= CSS_BWORD_ERASED;
         gen_cfg_r  <= CSS_GWORD_ERASED;
      end else if (wb_wr && lane0 && (wb_adr_i == CSS_REG_BOOT_CFG)) begin
         boot_cfg_r <= boot_cfg_r & wb_dat_i[CSS_BWORD_W-1:0];
      end else if (wb_wr && lane0 && (wb_adr_i == CSS_REG_GEN_CFG)) begin
         gen_cfg_r  <= gen_cfg_r & wb_dat_i[CSS_GWORD_W-1:0];
      end
   end

   // Sticky status: a new event wins over a write-one clear in the same cycle.
   always_comb begin
      status_nxt = status_r;
      if (wb_wr && lane0 && (wb_adr_i == CSS_REG_STATUS)) begin
         status_nxt = status_nxt & ~wb_dat_i[CSS_EV_W-1:0];
      end
      status_nxt = status_nxt | ev_set;
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         status_r <= '0;
      end else begin
         status_r <= status_nxt;
      end
   end

   always_comb begin
      mask_nxt = mask_r;
      if (wb_wr && lane0 && (wb_adr_i == CSS_REG_MASK)) begin
         mask_nxt = wb_dat_i[CSS_EV_W-1:0];
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         mask_r <= '0;
      end else begin
         mask_r <= mask_nxt;
      end
   end

   // Built from the next status and mask so the line tracks both without lag.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |(status_nxt & mask_nxt);
      end
   end

   // Read mux; unmapped offsets read as zero.
   always_comb begin
      rdat_nxt = '0;
      case (wb_adr_i)
         CSS_REG_BOOT_CFG: rdat_nxt[CSS_BWORD_W-1:0] = boot_cfg_r;
         CSS_REG_GEN_CFG:  rdat_nxt[CSS_GWORD_W-1:0] = gen_cfg_r;
         CSS_REG_STATUS:   rdat_nxt[CSS_EV_W-1:0]    = status_r;
         CSS_REG_MASK:     rdat_nxt[CSS_EV_W-1:0]    = mask_r;
         CSS_REG_STATE:    rdat_nxt[2:0]             = lvl;
         default:          rdat_nxt                  = '0;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdat_r <= '0;
      end else if (wb_req && !wb_we_i) begin
         rdat_r <= rdat_nxt;
      end
   end

   assign wb_dat_o       = rdat_r;
   assign wb_ack_o       = ack_r;
   assign irq            = irq_r;
   assign acc_resp       = resp_r;
   assign boot_cfg_image = boot_cfg_r;
   assign gen_cfg_image  = gen_cfg_r;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   logic past_ok_r;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         past_ok_r <= 1'b0;
      end else begin
         past_ok_r <= loaded_r;
      end
   end

   a_none_open:
      assert property (acc_req.valid && loaded_r && (boot_security_select == CSS_BSS_NONE) && !acc_req.from_port
                       && (acc_req.kind != CSS_ACC_WRITE) |=> acc_resp.grant)
      else $error("access refused with boot segment disabled");

   a_port_boot_rd:
      assert property (acc_req.valid && acc_req.from_port && (acc_req.kind == CSS_ACC_READ)
                       && boot_en && seg_in_boot[1] |=> acc_resp.deny && !acc_resp.grant)
      else $error("port read of boot flash not refused");

   a_cross_block:
      assert property (acc_req.valid && !acc_req.from_port && (acc_req.kind == CSS_ACC_READ)
                       && seg_in_boot[1] && !seg_in_boot[0] |=>
                       acc_resp.deny ##1 status_r[CSS_EV_CROSS])
      else $error("cross-segment read of boot flash not blocked");

   a_boot_self:
      assert property (acc_req.valid && !acc_req.from_port && (acc_req.kind == CSS_ACC_READ)
                       && seg_in_boot[0] |=> acc_resp.grant)
      else $error("boot code refused access to itself");

   a_entry_ok:
      assert property (acc_req.valid && !acc_req.from_port && (acc_req.kind == CSS_ACC_FLOW)
                       && (lvl == CSS_LVL_HIGH) && !seg_in_boot[0]
                       && (acc_req.target >= CSS_BOOT_START) && (acc_req.target <= CSS_ENTRY_END)
                       |=> acc_resp.grant && !acc_resp.illegal_reset)
      else $error("jump into entry window refused");

   a_entry_reset:
      assert property (acc_req.valid && !acc_req.from_port && (acc_req.kind == CSS_ACC_FLOW)
                       && (lvl == CSS_LVL_HIGH) && !seg_in_boot[0] && seg_in_boot[1]
                       && (acc_req.target > CSS_ENTRY_END) |=>
                       acc_resp.illegal_reset ##1 !acc_resp.illegal_reset || $past(acc_req.valid))
      else $error("illegal entry did not raise a one-cycle reset");

   a_gen_port_rd:
      assert property (acc_req.valid && acc_req.from_port && (acc_req.kind == CSS_ACC_READ)
                       && !seg_in_boot[1] |=> (acc_resp.deny == $past(!gss)))
      else $error("general port read outcome does not follow general select");

   a_wlock:
      assert property (acc_req.valid && (acc_req.kind == CSS_ACC_WRITE) && seg_in_boot[1]
                       && !boot_write_lock |=> acc_resp.deny)
      else $error("write to locked boot segment granted");

   a_only_clear:
      assert property (past_ok_r && !(wb_wr && (wb_adr_i == CSS_REG_CTRL)) |=>
                       ((boot_cfg_r & ~$past(boot_cfg_r)) == '0))
      else $error("config bit rose without bulk erase");

   a_bound_end:
      assert property (boot_en && (acc_req.target == CSS_BOOT_END_S + 24'h00_0001)
                       |-> (seg_in_boot[1] == (boot_end == CSS_BOOT_END_L)))
      else $error("boot segment end boundary wrong");

   a_irq_level:
      assert property (irq == |(status_r & mask_r))
      else $error("interrupt does not follow masked status");

   c_illegal_reset: cover property (acc_resp.illegal_reset);
   c_port_deny:     cover property (acc_resp.deny ##1 status_r[CSS_EV_PORT_RD]);
   c_erase:         cover property (wb_wr && (wb_adr_i == CSS_REG_CTRL)
                                    ##1 (boot_cfg_image == CSS_BWORD_ERASED));
   c_irq:           cover property ($rose(irq));

endmodule

//--- verification/css_core_model.sv
// Core and programmer side model that presents access requests to the block.
`timescale 1ns/1ps
module css_core_model
   import css_pkg::*;
(
   input  wire logic     core_clk,
   input  wire css_req_t cmd,
   output css_req_t      acc_req
);
   logic [CSS_AW-1:0] last_r = '0;
   always_ff @(posedge core_clk) begin
      last_r <= ~acc_req.pc;
   end
   // Idle address lines toggle every cycle so a stale request is never mistaken for a live one.
   always_comb begin
      acc_req = cmd;
      if (!cmd.valid) begin
         acc_req.pc     = last_r;
         acc_req.target = ~last_r;
      end
   end
endmodule

//--- verification/tb.sv
// Self-checking bench for the code segment security block.
`timescale 1ns/1ps
module tb
   import css_pkg::*;
;
   logic                   core_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i;
   logic [CSS_WB_AW-1:0]   wb_adr_i;
   logic [3:0]             wb_sel_i, st_m, mask_m, ev_c, bimg_m;
   logic [CSS_DW-1:0]      wb_dat_i, wb_dat_o, q;
   logic                   wb_ack_o, irq;
   logic [CSS_BWORD_W-1:0] bcfg, boot_cfg_image;
   logic [CSS_GWORD_W-1:0] gcfg, gen_cfg_image;
   css_req_t               cmd, acc_req;
   css_resp_t              acc_resp, exp_d;
   logic [2:0]             bsel;
   int                     lvl, mismatches, comparisons, cyc_n, seed;
   logic [CSS_AW-1:0]      adr_tab [8];

   css_top uut (.core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq), .boot_segment_config_word(bcfg),
      .general_segment_config_word(gcfg), .boot_cfg_image(boot_cfg_image),
      .gen_cfg_image(gen_cfg_image), .acc_req(acc_req), .acc_resp(acc_resp));
   css_core_model core (.core_clk(core_clk), .cmd(cmd), .acc_req(acc_req));

   always #25 core_clk = ~core_clk;

   task automatic print_verdict();
      if (mismatches == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   task automatic cmp_word(input string nm, input logic [31:0] e, input logic [31:0] s);
      comparisons++;
      if (s !== e) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic cmp_resp(input css_resp_t e, input css_resp_t s);
      comparisons++;
      if (s !== e) begin
         mismatches++;
         $display("CHECK FAILED acc_resp expected %b seen %b", e, s);
      end
   endtask
   task automatic cmp_bit(input logic e, input logic s);
      comparisons++;
      if (s !== e) begin
         mismatches++;
         $display("CHECK FAILED irq expected %b seen %b", e, s);
      end
   endtask

   function automatic logic in_boot(input logic [CSS_AW-1:0] a);
      logic [CSS_AW-1:0] e;
      e = (bsel == CSS_BSS_STD_S || bsel == CSS_BSS_HI_S) ?
          CSS_BOOT_END_S : CSS_BOOT_END_L;
      return lvl != 0 && a >= CSS_BOOT_START && a <= e;
   endfunction

   function automatic css_resp_t calc(input css_req_t r);
      logic t_b, p_b;
      t_b = in_boot(r.target);
      p_b = in_boot(r.pc);
      ev_c = '0;
      if (r.from_port && r.kind != CSS_ACC_WRITE)
         ev_c[CSS_EV_PORT_RD] = t_b || !gcfg[CSS_GSS_BIT];
      else if (r.kind inside {CSS_ACC_READ, CSS_ACC_WRITE} && !r.from_port && t_b && !p_b)
         ev_c[CSS_EV_CROSS] = 1'b1;
      else if (r.kind == CSS_ACC_WRITE)
         ev_c[CSS_EV_WLOCK] = !(t_b ? bcfg[CSS_BOOT_WRITE_LOCK_BIT] : gcfg[CSS_GENERAL_WRITE_LOCK_BIT]);
      else if (r.kind == CSS_ACC_FLOW)
         ev_c[CSS_EV_ENTRY] = lvl == 2 && !p_b && t_b
                              && r.target > CSS_ENTRY_END;
      if (!r.valid) ev_c = '0;
      return '{grant: r.valid && ev_c == 0, deny: ev_c != 0, illegal_reset: ev_c[CSS_EV_ENTRY]};
   endfunction

   task automatic wb(input logic we, input logic [CSS_WB_AW-1:0] a, input logic [31:0] d);
      int n;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      q = wb_dat_o;
      if (n >= 50) mismatches++;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
      if (we && a == CSS_REG_STATUS) st_m &= ~d[3:0];
      if (we && a == CSS_REG_MASK && wb_sel_i[0]) mask_m = d[3:0];
      if (we && a == CSS_REG_BOOT_CFG) bimg_m &= d[3:0];
      if (we && a == CSS_REG_CTRL && d[CSS_CTRL_ERASE_BIT]) bimg_m = CSS_BWORD_ERASED;
      @(posedge core_clk);
   endtask

   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         exp_d <= '0;
         st_m = '0;
      end else begin
         exp_d <= calc(acc_req);
         st_m = st_m | ev_c;
      end
   end

   always @(negedge core_clk) begin
      if (rst_n) begin
         cmp_resp(exp_d, acc_resp);
         if (!wb_cyc_i) cmp_bit(|(st_m & mask_m), irq);
      end
   end

   always @(posedge core_clk) begin
      cyc_n++;
      if (cyc_n == 20000) begin
         mismatches++;
         print_verdict();
      end
   end

   initial begin
      core_clk = 0; rst_n = 0; wb_cyc_i = 0; wb_stb_i = 0; wb_we_i = 0; wb_adr_i = '0;
      wb_sel_i = 4'hF; wb_dat_i = '0; cmd = '0; bcfg = '0; gcfg = '0; mask_m = '0;
      mismatches = 0; comparisons = 0; cyc_n = 0; seed = 3040;
      adr_tab = '{CSS_BOOT_START, CSS_ENTRY_END, CSS_ENTRY_END + 24'h00_0001,
                  CSS_BOOT_START - 24'h00_0001, CSS_BOOT_END_S, CSS_BOOT_END_S + 24'h00_0001,
                  CSS_BOOT_END_L, CSS_BOOT_END_L + 24'h00_0001};
      for (int c = 0; c < 64; c++) begin
         @(posedge core_clk);
         rst_n <= 1'b0;
         bcfg  <= c[3:0];
         gcfg  <= c[5:4];
         repeat (4) @(posedge core_clk);
         bsel = bcfg[CSS_BSS_LSB +: 3];
         lvl = bsel inside {CSS_BSS_STD_S, CSS_BSS_STD_L} ? 1 :
               bsel inside {CSS_BSS_HI_S, CSS_BSS_HI_L} ? 2 : 0;
         mask_m = '0;
         bimg_m = bcfg;
         rst_n <= 1'b1;
         repeat (2) @(posedge core_clk);
         cmp_word("gen_image", 32'(gcfg), 32'(gen_cfg_image));
         wb(1'b0, CSS_REG_STATE, '0);
         cmp_word("state", lvl == 0 ? 32'(CSS_LVL_NONE) : lvl == 1 ? 32'(CSS_LVL_STD) :
                  32'(CSS_LVL_HIGH), q);
         wb(1'b1, CSS_REG_MASK, 32'($random(seed)) & 32'h0000_000F);
         // A write without lane 0 enabled must leave the mask alone.
         wb_sel_i <= 4'hE;
         wb(1'b1, CSS_REG_MASK, 32'h0000_000F);
         wb_sel_i <= 4'hF;
         wb(1'b0, CSS_REG_MASK, '0);
         cmp_word("mask", 32'(mask_m), q);
         repeat (24) begin
            cmd <= '{valid: 1'b1, from_port: 1'($random(seed)),
                     kind: css_acc_t'(2'($random(seed))),
                     pc: adr_tab[$random(seed) & 7], target: adr_tab[$random(seed) & 7]};
            @(posedge core_clk);
         end
         cmd.valid <= 1'b0;
         @(posedge core_clk);
         wb(1'b0, CSS_REG_STATUS, '0);
         cmp_word("status", 32'(st_m), q);
         wb(1'b1, CSS_REG_STATUS, 32'($random(seed)) & 32'h0000_000F);
         wb(1'b0, CSS_REG_STATUS, '0);
         cmp_word("status_w1c", 32'(st_m), q);
         wb(1'b1, CSS_REG_BOOT_CFG, 32'($random(seed)));
         cmp_word("boot_image", 32'(bimg_m), 32'(boot_cfg_image));
         wb(1'b1, CSS_REG_CTRL, 32'h0000_0001);
         cmp_word("erased_image", 32'(bimg_m), 32'(boot_cfg_image));
         wb(1'b0, 8'h3C, '0);
         cmp_word("unmapped", 32'h0000_0000, q);
      end
      print_verdict();
   end
endmodule
